//--- core/scs_consts.svh
// constants for the single contact selection and speed block
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// selection command codes
`define SCS_CMD_SEARCH 8'hF0
`define SCS_CMD_MATCH 8'h55
`define SCS_CMD_SKIP 8'hCC
`define SCS_CMD_RESUME 8'hA5
`define SCS_CMD_OD_SKIP 8'h3C
`define SCS_CMD_OD_MATCH 8'h69

// frame sizes
`define SCS_CMD_BITS 8
`define SCS_ID_BITS 64

// clock rate
`define SCS_CLK_MHZ 100

// times in their own units
`define SCS_T_RST_STD_US 480
`define SCS_T_RST_OD_US 48
`define SCS_T_SMP_STD_NS 30000
`define SCS_T_SMP_OD_NS 3000
`define SCS_T_FILT_NS 300
`define SCS_T_REH_STD_NS 1000
`define SCS_T_REH_OD_NS 500

// least times rounded up to cycles
`define SCS_RST_STD_CYC (`SCS_T_RST_STD_US * `SCS_CLK_MHZ)
`define SCS_RST_OD_CYC (`SCS_T_RST_OD_US * `SCS_CLK_MHZ)
`define SCS_SMP_STD_CYC ((`SCS_T_SMP_STD_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_SMP_OD_CYC ((`SCS_T_SMP_OD_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_FILT_CYC ((`SCS_T_FILT_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_REH_STD_CYC ((`SCS_T_REH_STD_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_REH_OD_CYC ((`SCS_T_REH_OD_NS * `SCS_CLK_MHZ + 999) / 1000)

`endif

//--- core/scs_edge_front.sv
// slot start detector with falling edge filter and rising edge hold-off
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_edge_front import scs_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// synchronised line level and speed
	input wire logic i_line,
	input wire logic i_od,
	// slot status
	output scs_front_t o_front
);

	logic [7:0] filt_q;
	logic [7:0] filt_d;
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	logic in_slot_q;
	logic start_q;
	logic filt_done;
	logic low_ok;
	logic rise;
	logic take;

	// low run length, saturating one below the filter length
	assign filt_done = (filt_q >= 8'(`SCS_FILT_CYC - 1));
	assign filt_d = i_line ? 8'h00 : (filt_done ? filt_q : filt_q + 8'h01);
	// filter only at standard speed
	assign low_ok = !i_line && (i_od || filt_done);
	// end of slot, hold-off window opens
	assign rise = in_slot_q && i_line;
	// low after hold-off is a slot start, even if it began inside it
	assign take = !in_slot_q && (hold_q == 8'h00) && low_ok;
	assign hold_d = rise ? (i_od ? 8'(`SCS_REH_OD_CYC) : 8'(`SCS_REH_STD_CYC)) :
		((hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00);

	// filter and hold-off counters
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			filt_q <= 8'h00;
			hold_q <= 8'h00;
		end else begin
			filt_q <= filt_d;
			hold_q <= hold_d;
		end
	end

	// slot state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			in_slot_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			in_slot_q <= take ? 1'b1 : (rise ? 1'b0 : in_slot_q);
			start_q <= take;
		end
	end

	assign o_front = '{start: start_q, in_slot: in_slot_q};

endmodule

//--- core/scs_pkg.sv
// types for the single contact selection and speed block
package scs_pkg;

	// network layer states, gray along idle-cmd-addr-search-select-deselect
	typedef enum logic [2:0] {
		SCS_ST_IDLE = 3'b000,
		SCS_ST_CMD = 3'b001,
		SCS_ST_ADDR = 3'b011,
		SCS_ST_SEARCH = 3'b010,
		SCS_ST_SEL = 3'b110,
		SCS_ST_DESEL = 3'b111
	} scs_state_t;

	// one received bit handed to the function layer
	typedef struct packed {
		logic valid;
		logic value;
	} scs_bit_t;

	// slot front end status
	typedef struct packed {
		logic start;
		logic in_slot;
	} scs_front_t;

endpackage

//--- core/scs_select_top.sv
// network selection and speed control behind the single contact pin
`timescale 1ns/1ps
`include "scs_consts.svh"

// How it works
// - commands are eight bits after presence
// - skip code selects without identifier
// - resume selects when resume flag set
// - match, search, overdrive-match set resume flag
// - failed match or lost search clears resume flag
// - overdrive-skip sets overdrive and selects
// - long reset pulse clears overdrive
// - overdrive-match sends code then identifier, match sets overdrive
// - only full 64-bit match selects
// - mismatched device idles until reset
// - overdrive kept when another device matched
// - falling edge filter at standard speed only
// - glitches ignored during rising edge hold-off
// - low beyond hold-off starts a slot
module scs_select_top import scs_pkg::*; #(
	parameter int RST_STD_CYC = `SCS_RST_STD_CYC,
	parameter int RST_OD_CYC = `SCS_RST_OD_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// bus pin, receive side
	input wire logic i_line,
	// stored identifier
	input wire logic [63:0] i_rom_id,
	// search engine answer
	input wire logic i_search_done,
	input wire logic i_search_won,
	// speed and selection state
	output logic o_overdrive,
	output logic o_resume_flag,
	output logic o_selected,
	output logic o_search_req,
	output logic o_reset_seen,
	// bits for the function layer
	output scs_bit_t o_fn_bit
);

	scs_state_t state_q;
	scs_state_t state_d;
	scs_front_t front;
	logic sync1_q;
	logic sync2_q;
	logic slot_prev_q;
	logic [16:0] low_q;
	logic [16:0] low_d;
	logic smp_q;
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic mis_q;
	logic mis_d;
	logic od_q;
	logic od_d;
	logic rc_q;
	logic rc_d;
	logic sel_q;
	logic sreq_q;
	logic rst_seen_q;
	scs_bit_t fn_q;
	logic [16:0] smp_at;
	logic slot_end;
	logic rst_hit;
	logic long_rst;
	logic bit_ev;
	logic cmd_last;
	logic id_last;
	logic id_bit;
	logic [7:0] cmd;
	logic bad_bit;

	// low time reaches a limit
	function automatic logic reached(input logic [16:0] c, input int lim);
		reached = (c >= 17'(lim));
	endfunction

	// two flip-flop synchroniser for the pin
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= i_line;
			sync2_q <= sync1_q;
		end
	end

	scs_edge_front u_front (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_line(sync2_q),
		.i_od(od_q),
		.o_front(front)
	);

	// slot timing decode
	assign smp_at = od_q ? 17'(`SCS_SMP_OD_CYC) : 17'(`SCS_SMP_STD_CYC);
	assign low_d = front.start ? 17'h00000 : ((&low_q) ? low_q : low_q + 17'h00001);
	assign slot_end = slot_prev_q && !front.in_slot;
	assign rst_hit = reached(low_q, od_q ? RST_OD_CYC : RST_STD_CYC);
	assign long_rst = reached(low_q, RST_STD_CYC);
	assign bit_ev = slot_end && !rst_hit;

	// low time counter and write sample
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_prev_q <= 1'b0;
			low_q <= 17'h00000;
			smp_q <= 1'b0;
		end else begin
			slot_prev_q <= front.in_slot;
			low_q <= low_d;
			// a slot that ends before the sample point is a write one
			smp_q <= front.start ? 1'b1 : ((front.in_slot && low_q == smp_at) ? sync2_q : smp_q);
		end
	end

	// bit framing decode
	assign cmd = {smp_q, sh_q[7:1]};
	assign cmd_last = (cnt_q == 7'(`SCS_CMD_BITS - 1));
	assign id_last = (cnt_q == 7'(`SCS_ID_BITS - 1));
	assign id_bit = i_rom_id[cnt_q[5:0]];
	assign bad_bit = mis_q || (smp_q != id_bit);

	// network layer sequencing
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		mis_d = mis_q;
		od_d = od_q;
		rc_d = rc_q;
		if (slot_end && rst_hit) begin
			state_d = SCS_ST_CMD;
			cnt_d = 7'h00;
			mis_d = 1'b0;
			if (long_rst) begin
				od_d = 1'b0;
			end
		end else begin
			case (state_q)
				SCS_ST_CMD: begin
					if (bit_ev) begin
						sh_d = cmd;
						cnt_d = cmd_last ? 7'h00 : cnt_q + 7'h01;
						if (cmd_last) begin
							case (cmd)
								`SCS_CMD_SKIP: state_d = SCS_ST_SEL;
								`SCS_CMD_RESUME: state_d = rc_q ? SCS_ST_SEL : SCS_ST_DESEL;
								`SCS_CMD_OD_SKIP: begin
									od_d = 1'b1;
									state_d = SCS_ST_SEL;
								end
								`SCS_CMD_MATCH: state_d = SCS_ST_ADDR;
								`SCS_CMD_OD_MATCH: state_d = SCS_ST_ADDR;
								`SCS_CMD_SEARCH: state_d = SCS_ST_SEARCH;
								default: state_d = SCS_ST_DESEL;
							endcase
						end
					end
				end
				SCS_ST_ADDR: begin
					if (bit_ev) begin
						mis_d = bad_bit;
						cnt_d = cnt_q + 7'h01;
						if (id_last) begin
							state_d = bad_bit ? SCS_ST_DESEL : SCS_ST_SEL;
							rc_d = !bad_bit;
							// a mismatch leaves the speed flag alone
							od_d = (!bad_bit && sh_q == `SCS_CMD_OD_MATCH) ? 1'b1 : od_q;
						end
					end
				end
				SCS_ST_SEARCH: begin
					if (i_search_done) begin
						state_d = i_search_won ? SCS_ST_SEL : SCS_ST_DESEL;
						rc_d = i_search_won;
					end
				end
				SCS_ST_SEL: state_d = SCS_ST_SEL;
				SCS_ST_DESEL: state_d = SCS_ST_DESEL;
				SCS_ST_IDLE: state_d = SCS_ST_IDLE;
				default: state_d = SCS_ST_IDLE;
			endcase
		end
	end

	// state and flags
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= SCS_ST_IDLE;
			cnt_q <= 7'h00;
			sh_q <= 8'h00;
			mis_q <= 1'b0;
			od_q <= 1'b0;
			rc_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			mis_q <= mis_d;
			od_q <= od_d;
			rc_q <= rc_d;
		end
	end

	// registered outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sel_q <= 1'b0;
			sreq_q <= 1'b0;
			rst_seen_q <= 1'b0;
			fn_q <= '{valid: 1'b0, value: 1'b0};
		end else begin
			sel_q <= (state_d == SCS_ST_SEL);
			sreq_q <= (state_d == SCS_ST_SEARCH);
			rst_seen_q <= slot_end && rst_hit;
			fn_q <= '{valid: bit_ev && state_q == SCS_ST_SEL, value: smp_q};
		end
	end

	assign o_overdrive = od_q;
	assign o_resume_flag = rc_q;
	assign o_selected = sel_q;
	assign o_search_req = sreq_q;
	assign o_reset_seen = rst_seen_q;
	assign o_fn_bit = fn_q;

endmodule

//--- sim/scs_host_model.sv
// bus controller model driving the single contact line
`timescale 1ns/1ps
module scs_host_model (
	input wire logic i_clk,
	output logic o_line
);
	int od = 0;
	initial o_line = 1'b1;
	// hold a level for n cycles
	task automatic drive(input logic v, input int n);
		o_line <= v;
		repeat (n) @(posedge i_clk);
	endtask
	// reset pulse, short one at overdrive keeps the speed
	task automatic bus_reset(input bit lng);
		drive(1'b0, lng ? 4100 : 1100);
		drive(1'b1, 200);
		if (lng)
			od = 0;
	endtask
	// write slot, low time picks the bit
	task automatic slot(input logic b);
		drive(1'b0, b ? (od ? 20 : 100) : (od ? 400 : 3100));
		drive(1'b1, od ? 80 : 130);
	endtask
	// n bits lsb first
	task automatic send(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
			slot(v[i]);
	endtask
endmodule

//--- sim/scs_select_sva.sv
// port assertions for the selection and speed block
`timescale 1ns/1ps
module scs_select_sva import scs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic o_overdrive,
	input wire logic o_resume_flag,
	input wire logic o_selected,
	input wire logic o_search_req,
	input wire logic o_reset_seen,
	input wire scs_bit_t o_fn_bit
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_od_rise_sel: assert property ($rose(o_overdrive) |-> o_selected)
		else $error("overdrive rose without selection");
	a_od_fall_rst: assert property ($fell(o_overdrive) |-> o_reset_seen || $past(o_reset_seen))
		else $error("overdrive cleared without reset");
	a_sel_fall_rst: assert property ($fell(o_selected) |-> o_reset_seen || $past(o_reset_seen))
		else $error("selection lost without reset");
	a_bit_needs_sel: assert property (o_fn_bit.valid |-> o_selected)
		else $error("bit passed while not selected");
	a_bit_gap: assert property (o_fn_bit.valid |=> (!o_fn_bit.valid) [*8])
		else $error("bit pulses too close");
	a_rst_one: assert property (o_reset_seen |=> !o_reset_seen)
		else $error("reset pulse too long");
	a_rst_no_bit: assert property (o_reset_seen |-> !o_fn_bit.valid)
		else $error("bit taken from a reset");
	a_resume_set: assert property ($rose(o_resume_flag) |-> o_selected)
		else $error("resume flag set without selection");
	a_resume_clr: assert property ($fell(o_resume_flag) |-> !o_selected)
		else $error("resume flag cleared while selected");
	a_search_no_sel: assert property (o_search_req |-> !o_selected)
		else $error("search pending while selected");
endmodule

//--- sim/scs_select_top_bench.sv
// self-checking bench for the selection and speed block
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_select_top_bench;
	import scs_pkg::*;
	logic i_clk;
	logic i_rst;
	logic line;
	logic od, rf, sel, sr, rs, lastv;
	scs_bit_t fb;
	logic srch_done = 1'b0;
	logic srch_won = 1'b0;
	int nv, nr, failures, n_checks;
	logic [63:0] id = 64'hF7DE_FBEF_7DF7_BEFD;
	// one device on the bus
	scs_host_model h (.i_clk(i_clk), .o_line(line));
	scs_select_top #(.RST_STD_CYC(4000), .RST_OD_CYC(1000)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_line(line), .i_rom_id(id),
		.i_search_done(srch_done), .i_search_won(srch_won), .o_overdrive(od),
		.o_resume_flag(rf), .o_selected(sel), .o_search_req(sr),
		.o_reset_seen(rs), .o_fn_bit(fb));
	// clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// count bit and reset pulses
	always @(posedge i_clk) begin
		if (fb.valid === 1'b1) begin
			nv++;
			lastv = fb.value;
		end
		if (rs === 1'b1)
			nr++;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %0h got %0h", n, e, g);
		end
	endtask
	// flags as overdrive, resume, selected
	task automatic fl(input logic [2:0] e);
		chk("flags", {29'h0, e}, {29'h0, od, rf, sel});
	endtask
	task automatic t_resume_clear;
		int v;
		v = nr;
		h.bus_reset(1);
		chk("resets", v + 1, nr);
		h.send(`SCS_CMD_RESUME, 8);
		v = nv;
		h.slot(1'b1);
		fl(3'b000);
		chk("bits", v, nv);
	endtask
	task automatic t_skip;
		int v;
		h.bus_reset(1);
		h.send(`SCS_CMD_SKIP, 8);
		fl(3'b001);
		v = nv;
		h.drive(1'b0, 10);
		h.drive(1'b1, 150);
		h.slot(1'b1);
		chk("bits", v + 1, nv);
		chk("value", 1, {31'h0, lastv});
	endtask
	task automatic t_od_skip;
		h.bus_reset(1);
		h.send(`SCS_CMD_OD_SKIP, 8);
		fl(3'b101);
		h.od = 1;
	endtask
	task automatic t_od_match;
		int v;
		h.bus_reset(0);
		fl(3'b100);
		h.send(`SCS_CMD_OD_MATCH, 8);
		h.send(id, 64);
		fl(3'b111);
		v = nv;
		h.drive(1'b0, 20);
		h.drive(1'b1, 10);
		h.drive(1'b0, 10);
		h.drive(1'b1, 80);
		chk("bits", v + 1, nv);
		// low begun inside hold-off, lasting past it
		h.drive(1'b0, 20);
		h.drive(1'b1, 10);
		h.drive(1'b0, 60);
		h.drive(1'b1, 80);
		chk("bits", v + 3, nv);
	endtask
	task automatic t_resume;
		for (int i = 0; i < 2; i++) begin
			h.bus_reset(0);
			h.send(`SCS_CMD_RESUME, 8);
			fl(3'b111);
		end
	endtask
	// search handed to the outside engine, won or lost
	task automatic t_search(input logic w);
		h.bus_reset(0);
		h.send(`SCS_CMD_SEARCH, 8);
		chk("search_req", 1, {31'h0, sr});
		srch_won <= w;
		srch_done <= 1'b1;
		@(posedge i_clk);
		srch_done <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("search_req", 0, {31'h0, sr});
		fl({1'b1, w, w});
	endtask
	task automatic t_mismatch;
		int v;
		h.bus_reset(0);
		h.send(`SCS_CMD_MATCH, 8);
		h.send(id ^ 64'h8000_0000_0000_0000, 64);
		fl(3'b100);
		v = nv;
		h.slot(1'b1);
		chk("bits", v, nv);
		h.bus_reset(0);
		h.send(`SCS_CMD_RESUME, 8);
		fl(3'b100);
	endtask
	task automatic t_long;
		h.bus_reset(1);
		fl(3'b000);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog
	initial begin
		#1200000;
		failures++;
		end_sim;
	end
	initial begin
		i_rst = 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_resume_clear;
		t_skip;
		t_od_skip;
		t_od_match;
		t_resume;
		t_search(1'b0);
		t_search(1'b1);
		t_mismatch;
		t_long;
		end_sim;
	end
endmodule
bind scs_select_top scs_select_sva chk_i (.i_clk(i_clk), .i_rst(i_rst),
	.o_overdrive(o_overdrive), .o_resume_flag(o_resume_flag),
	.o_selected(o_selected), .o_search_req(o_search_req), .o_reset_seen(o_reset_seen),
	.o_fn_bit(o_fn_bit));
